// *** bench/bpl_link_assist_tb_top.sv ***
// self-checking bench for the pwm link assist
`timescale 1ns/1ns
module bpl_link_assist_tb_top;
  import bpl_pkg::*;
  localparam int UNIT = 380;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic        tx_low_req = 1'b0;
  logic        sta_clr = 1'b0;
  logic        pw_ready = 1'b0;
  logic [15:0] low_cyc = 16'h0000;
  logic [15:0] ctl = 16'h0000;
  logic [15:0] cmp = 16'h0000;
  logic [15:0] seed = 16'h0005;
  logic [15:0] pw_data, run_t, brk_t, cap;
  logic [7:0]  sta;
  logic        m_low, pw_valid, link_irq, wake_irq, line_out, line_oe;
  int          mismatches = 0;
  int          checks_done = 0;
  int          wake_cnt = 0;
  int          link_cnt = 0;
  int          un [3];
  int          n;
  wire         line_in = ~(m_low | line_oe);
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    wake_cnt <= wake_cnt + int'(wake_irq);
    link_cnt <= link_cnt + int'(link_irq);
  end
  bpl_master_model u_bpl_master_model (.sys_clk(sys_clk), .go(go),
    .low_cyc(low_cyc), .master_low(m_low));
  bpl_link_assist u_bpl_link_assist (.sys_clk(sys_clk), .rst(rst),
    .line_in(line_in), .sync_control_reg(ctl), .pulse_compare_reg(cmp),
    .tx_low_req(tx_low_req), .sta_clr(sta_clr), .pw_ready(pw_ready),
    .pw_valid(pw_valid), .pw_data(pw_data), .sync_run_timer(run_t),
    .pulse_break_timer(brk_t), .edge_capture_reg(cap),
    .sync_status_reg(sta), .link_irq(link_irq), .wake_irq(wake_irq),
    .line_out(line_out), .line_oe(line_oe));
  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 7);
    seed = seed ^ (seed >> 9);
    seed = seed ^ (seed << 8);
    return seed;
  endfunction
  // bit class from break ticks: sync, zero, one
  function automatic logic [15:0] cls(input logic [15:0] t);
    return (t < 16'h0004) ? 16'h0000 : (t < 16'h0009) ? 16'h0001 : 16'h0002;
  endfunction
  function automatic logic [15:0] ucls(input int u);
    return (u == SYNC_UNITS) ? 16'h0000 : (u == ZERO_UNITS) ? 16'h0001
      : 16'h0002;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
    #2;
  endtask
  task automatic pulse(input int u);
    go = 1'b1;
    low_cyc = 16'(u * UNIT);
    cyc(1);
    go = 1'b0;
    cyc(u * UNIT + 10);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    mismatches++;
    conclude();
  end
  initial begin
    cyc(10);
    rst = 1'b0;
    cyc(4);
    chk(cap, CAP_RESET);
    chk(run_t, 16'h0000);
    chk({8'h00, sta}, 16'h0000);
    $display("test reset done");
    ctl = 16'h0148;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 3; i++) begin
        n = int'(xs() % 16'h0003);
        un[i] = (r == 0) ? i : n;
        un[i] = (un[i] == 0) ? SYNC_UNITS : (un[i] == 1) ? ZERO_UNITS
          : ONE_UNITS;
        pulse(un[i]);
        chk({15'h0000, sta[STA_BREAK_BIT]}, 16'h0001);
      end
      pw_ready = 1'b1;
      for (int j = 0; j < 2; j++) begin
        chk({15'h0000, pw_valid}, 16'h0001);
        chk(cls(pw_data), ucls(un[j]));
        cyc(1);
      end
      chk({15'h0000, pw_valid}, 16'h0000);
      chk(cls(brk_t), ucls(un[2]));
      pw_ready = 1'b0;
      $display("test rx round %0d done", r);
    end
    chk(16'(wake_cnt), 16'h0006);
    chk(16'(link_cnt), 16'h0006);
    n = un[2] * UNIT / SYNC_DIV;
    chk({15'h0000, 16'(run_t - cap) >= 16'(n)
      && 16'(run_t - cap) <= 16'(n + 3)}, 16'h0001);
    sta_clr = 1'b1;
    cyc(1);
    sta_clr = 1'b0;
    chk({8'h00, sta}, 16'h0000);
    ctl = 16'h0060;
    cmp = run_t + 16'h0014;
    tx_low_req = 1'b1;
    cyc(1);
    tx_low_req = 1'b0;
    chk({15'h0000, line_oe}, 16'h0001);
    chk({15'h0000, line_in}, 16'h0000);
    chk({15'h0000, line_out}, 16'h0000);
    n = 0;
    while (link_irq !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk({15'h0000, n > 90 && n < 110}, 16'h0001);
    chk(run_t, cmp);
    chk({15'h0000, sta[STA_CMP_BIT]}, 16'h0001);
    cyc(2);
    chk({15'h0000, line_oe}, 16'h0000);
    chk(16'(wake_cnt), 16'h0006);
    $display("test tx done");
    conclude();
  end
endmodule

// *** bench/bpl_master_model.sv ***
// master ecu model: pulls the single wire low for a set time
`timescale 1ns/1ns
module bpl_master_model (
  input  wire logic        sys_clk,
  input  wire logic        go,
  input  wire logic [15:0] low_cyc,
  output logic             master_low
);
  logic [15:0] left = 16'h0000;
  // released wire floats to the pull-up
  assign master_low = (left != 16'h0000);
  always @(posedge sys_clk) begin
    if (go) begin
      left <= low_cyc;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
    end
  end
endmodule

// *** verilog/bpl_link_assist.sv ***
// hardware assist for the single-wire pwm link: timers, capture, compare
`timescale 1ns/1ns
module bpl_link_assist #(
  parameter int TMR_W = 16,
  parameter int BUF_W = 16
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  line_in,
  input  wire logic [bpl_pkg::CTL_W-1:0] sync_control_reg,
  input  wire logic [TMR_W-1:0]      pulse_compare_reg,
  input  wire logic                  tx_low_req,
  input  wire logic                  sta_clr,
  input  wire logic                  pw_ready,
  output logic                       pw_valid,
  output logic [BUF_W-1:0]           pw_data,
  output logic [TMR_W-1:0]           sync_run_timer,
  output logic [TMR_W-1:0]           pulse_break_timer,
  output logic [TMR_W-1:0]           edge_capture_reg,
  output logic [bpl_pkg::STA_W-1:0]  sync_status_reg,
  output logic                       link_irq,
  output logic                       wake_irq,
  output logic                       line_out,
  output logic                       line_oe
);
  import bpl_pkg::*;

  initial begin
    if (TMR_W != 16 || BUF_W != TMR_W) begin
      $error("bpl_link_assist: timers and buffer must be 16 bits");
    end
    if (SYNC_DIV < 2 || SYNC_DIV > 256 || BREAK_DIV > 256) begin
      $error("bpl_link_assist: clock dividers must fit eight bits");
    end
  end

  typedef struct packed {
    logic              s1;
    logic              s2;
    logic              s3;
    logic [7:0]        sdiv;
    logic [7:0]        bdiv;
    logic [TMR_W-1:0]  run;
    logic [TMR_W-1:0]  brk;
    logic              brk_on;
    logic [TMR_W-1:0]  cap;
    logic [STA_W-1:0]  sta;
    logic              irq;
    logic              wake;
    logic              lo;
    logic              oe;
    logic [1:0]        cnt;
    logic              wp;
    logic [BUF_W-1:0]  b0;
    logic [BUF_W-1:0]  b1;
  } bpl_state_t;

  bpl_state_t st;
  bpl_state_t next_st;

  logic mode;
  logic fall;
  logic rise;
  logic stick;
  logic btick;
  logic push;
  logic pop;
  logic cmp_hit;

  always_comb begin
    mode    = sync_control_reg[CTL_BSD_MODE_BIT];
    fall    = st.s3 & ~st.s2;
    rise    = ~st.s3 & st.s2;
    stick   = st.sdiv == 8'(SYNC_DIV - 1);
    btick   = st.bdiv == 8'(BREAK_DIV - 1);
    // compare per 5 MHz count, so a match fires on its exact count
    // compare value is kept outside and read on every tick
    cmp_hit = mode & stick & sync_control_reg[CTL_CMP_EN_BIT]
            & (TMR_W'(st.run + 1'b1) == pulse_compare_reg);
    push    = mode & rise & st.brk_on
            & sync_control_reg[CTL_RISE_IRQ_BIT];
    pop     = pw_ready & (st.cnt != 2'd0);
    next_st = st;
    next_st.s1 = line_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.sdiv = stick ? 8'h00 : 8'(st.sdiv + 1'b1);
    next_st.bdiv = btick ? 8'h00 : 8'(st.bdiv + 1'b1);
    if (mode && stick) begin
      next_st.run = TMR_W'(st.run + 1'b1);
    end
    if (mode && fall) begin
      next_st.cap    = st.run;
      next_st.brk    = '0;
      next_st.brk_on = 1'b1;
    end else if (mode && rise) begin
      next_st.brk_on = 1'b0;
    end else if (st.brk_on && btick && ~&st.brk) begin
      next_st.brk = TMR_W'(st.brk + 1'b1);
    end
    // clear first so a same-cycle event wins
    if (sta_clr) begin
      next_st.sta = '0;
    end
    if (push) begin
      next_st.sta[STA_BREAK_BIT] = 1'b1;
    end
    if (cmp_hit) begin
      next_st.sta[STA_CMP_BIT] = 1'b1;
    end
    if (fall && sync_control_reg[CTL_START_IE_BIT]) begin
      next_st.sta[STA_START_BIT] = 1'b1;
    end
    next_st.irq  = push | cmp_hit;
    next_st.wake = fall & sync_control_reg[CTL_START_IE_BIT];
    // drive low from request until the compare match releases the line
    if (tx_low_req) begin
      next_st.lo = 1'b1;
    end else if (cmp_hit) begin
      next_st.lo = 1'b0;
    end
    next_st.oe = next_st.lo;
    // two-entry pulse-width buffer, word lost only when both full
    // software rebuilds frame fields from these widths
    if (pop) begin
      next_st.b0 = st.b1;
    end
    if (push && (st.cnt != 2'd2 || pop)) begin
      if (pop ? st.cnt == 2'd1 : st.cnt == 2'd0) begin
        next_st.b0 = st.brk;
      end else begin
        next_st.b1 = st.brk;
      end
    end
    next_st.cnt = 2'(st.cnt + (push && (st.cnt != 2'd2 || pop))
                - pop);
    next_st.wp = next_st.cnt != 2'd0;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st       <= '0;
      st.s1    <= 1'b1;
      st.s2    <= 1'b1;
      st.s3    <= 1'b1;
      st.cap   <= CAP_RESET;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    pw_valid          = st.wp;
    pw_data           = st.b0;
    sync_run_timer    = st.run;
    pulse_break_timer = st.brk;
    edge_capture_reg  = st.cap;
    sync_status_reg   = st.sta;
    link_irq          = st.irq;
    wake_irq          = st.wake;
    line_out          = 1'b0;
    line_oe           = st.oe;
  end

  AST_CAPTURE: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode && fall) |=> edge_capture_reg == $past(st.run))
    else $error("capture missed the falling edge");

  AST_BREAK_CLR: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode && fall) |=> pulse_break_timer == '0 && st.brk_on)
    else $error("break timer not cleared on fall");

  AST_BREAK_STOP: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode && rise && !fall) |=> !st.brk_on ##1 $stable(pulse_break_timer))
    else $error("break timer kept running");

  AST_CMP_FLAG: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmp_hit |=> sync_status_reg[STA_CMP_BIT] && link_irq)
    else $error("compare match not flagged");

  AST_CMP_EXACT: assert property (
    @(posedge sys_clk) disable iff (rst)
    cmp_hit |=> sync_run_timer == pulse_compare_reg)
    else $error("compare fired off its count");

  AST_RUN_STEP: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode && stick) |=> sync_run_timer == TMR_W'($past(st.run) + 1'b1))
    else $error("sync timer missed a tick");

  AST_RUN_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    !mode |=> $stable(sync_run_timer))
    else $error("sync timer ran outside link mode");

  AST_RISE_IRQ: assert property (
    @(posedge sys_clk) disable iff (rst)
    push |=> sync_status_reg[STA_BREAK_BIT] && pw_valid)
    else $error("rising edge interrupt missing");

  AST_WAKE: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fall && sync_control_reg[CTL_START_IE_BIT]) |=> wake_irq)
    else $error("start condition did not wake");

  AST_RELEASE: assert property (
    @(posedge sys_clk) disable iff (rst)
    (cmp_hit && !tx_low_req) |=> !line_oe)
    else $error("line not released on compare");

  AST_TX_DRIVE: assert property (
    @(posedge sys_clk) disable iff (rst)
    tx_low_req |=> line_oe)
    else $error("line not driven on request");

  AST_OE_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    (line_oe && !cmp_hit) |=> line_oe)
    else $error("line released before compare");

  AST_OE_IDLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!line_oe && !tx_low_req) |=> !line_oe)
    else $error("line driven without request");

  AST_WAKE_ONE: assert property (
    @(posedge sys_clk) disable iff (rst)
    wake_irq |=> !wake_irq)
    else $error("wake pulse longer than one cycle");

  AST_START_FLAG: assert property (
    @(posedge sys_clk) disable iff (rst)
    (fall && sync_control_reg[CTL_START_IE_BIT])
      |=> sync_status_reg[STA_START_BIT])
    else $error("start flag not set");

  AST_NO_WAKE: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(fall && sync_control_reg[CTL_START_IE_BIT]) |=> !wake_irq)
    else $error("wake without enabled falling edge");

  AST_CAP_HOLD: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(mode && fall) |=> $stable(edge_capture_reg))
    else $error("capture changed without an edge");

  AST_BRK_SAT: assert property (
    @(posedge sys_clk) disable iff (rst)
    (st.brk_on && &st.brk && !(mode && fall)) |=> &pulse_break_timer)
    else $error("break timer wrapped");

  AST_BRK_IDLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!st.brk_on && !(mode && fall)) |=> $stable(pulse_break_timer))
    else $error("stopped break timer moved");

  AST_NO_IRQ: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!push && !cmp_hit) |=> !link_irq)
    else $error("link interrupt without cause");

  AST_RUN_IDLE: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode && !stick) |=> $stable(sync_run_timer))
    else $error("sync timer moved between ticks");

  AST_CMP_OFF: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!sync_control_reg[CTL_CMP_EN_BIT] && !push) |=> !link_irq)
    else $error("compare fired while disabled");

  AST_STA_STICKY: assert property (
    @(posedge sys_clk) disable iff (rst)
    !sta_clr |=> (sync_status_reg & $past(st.sta)) == $past(st.sta))
    else $error("status bit dropped without clear");

  AST_STA_CLR: assert property (
    @(posedge sys_clk) disable iff (rst)
    (sta_clr && !push && !cmp_hit
      && !(fall && sync_control_reg[CTL_START_IE_BIT]))
      |=> sync_status_reg == '0)
    else $error("status not cleared");

  AST_BUF_LIMIT: assert property (
    @(posedge sys_clk) disable iff (rst)
    st.cnt != 2'd3)
    else $error("buffer count out of range");

  AST_BUF_PUSH: assert property (
    @(posedge sys_clk) disable iff (rst)
    (push && st.cnt == 2'd0) |=> pw_valid && pw_data == $past(st.brk))
    else $error("pushed width not at buffer head");

  AST_BUF_POP: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pop && st.cnt == 2'd2) |=> pw_valid && pw_data == $past(st.b1))
    else $error("buffer did not advance");

  AST_BUF_EMPTY: assert property (
    @(posedge sys_clk) disable iff (rst)
    (pop && st.cnt == 2'd1 && !push) |=> !pw_valid)
    else $error("buffer valid after last pop");

  AST_BUF_KEEP: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!pop && st.cnt != 2'd0) |=> pw_valid && $stable(pw_data))
    else $error("buffer head changed while stalled");

  COV_TX: cover property (@(posedge sys_clk) tx_low_req ##[1:50] cmp_hit);
  COV_RX: cover property (@(posedge sys_clk) fall ##[1:900] push);
  COV_FULL: cover property (@(posedge sys_clk) st.cnt == 2'd2);
  COV_WAKE: cover property (@(posedge sys_clk) wake_irq);
  COV_POP_FULL: cover property (@(posedge sys_clk)
    pop && st.cnt == 2'd2);
endmodule

// *** verilog/bpl_pkg.sv ***
// constants for the single-wire pwm link assist
package bpl_pkg;
  localparam int          SYS_CLK_HZ       = 25_000_000;
  localparam int          SYNC_TICK_HZ     = 5_000_000;
  localparam int          BREAK_TICK_HZ    = 131_000;
  localparam int          SYNC_DIV         = SYS_CLK_HZ / SYNC_TICK_HZ;
  localparam int          BREAK_DIV        = SYS_CLK_HZ / BREAK_TICK_HZ;
  localparam int          CTL_W            = 16;
  localparam int          CTL_START_IE_BIT = 3;
  localparam int          CTL_CMP_EN_BIT   = 5;
  localparam int          CTL_BSD_MODE_BIT = 6;
  localparam int          CTL_RISE_IRQ_BIT = 8;
  localparam int          STA_W            = 8;
  localparam int          STA_BREAK_BIT    = 0;
  localparam int          STA_START_BIT    = 1;
  localparam int          STA_CMP_BIT      = 3;
  localparam logic [15:0] CAP_RESET        = 16'h0000;
  localparam logic [15:0] CMP_RESET        = 16'h0000;
  localparam int          FRAME_PAUSE_W    = 3;
  localparam int          FRAME_ADDR_W     = 3;
  localparam int          FRAME_REG_W      = 4;
  localparam int          FRAME_DATA_W     = 8;
  localparam int          REG_WRITE_BIT    = 3;
  localparam logic        DIR_MASTER_REQ   = 1'b0;
  localparam logic        ACK_OK           = 1'b0;
  localparam int          SYNC_UNITS       = 1;
  localparam int          ZERO_UNITS       = 3;
  localparam int          ONE_UNITS        = 6;
endpackage
